// [rtl/irb_addr_gen.sv]
// Purpose: operand address and program counter update for later addressing modes
// Assumes: decoder presents opcode fields and fetched bytes with a one-cycle strobe
// Notes: results appear one cycle after start_in
`timescale 1ns/10ps
module irb_addr_gen
  import irb_pkg::*;
#(
  parameter int unsigned ADDR_W = IRB_AW,
  parameter int unsigned DATA_W = IRB_DW
)
(
  // clock and reset
  input  wire logic        clk_in,
  input  wire logic        rstn_in,
  // request from decode
  input  wire logic        start_in,
  input  wire irb_op_e     mode_in,
  input  wire logic [15:0] pc_in,
  input  wire logic [7:0]  index_in,
  input  wire logic [7:0]  byte1_in,
  input  wire logic [7:0]  byte2_in,
  input  wire logic        cond_in,
  input  wire logic [2:0]  bit_sel_in,
  input  wire logic        bit_pol_in,
  input  wire logic [7:0]  mem_data_in,
  // results
  output logic             done_out,
  output logic [15:0]      operand_address_out,
  output logic [15:0]      test_byte_address_out,
  output logic [15:0]      branch_target_address_out,
  output logic [15:0]      pc_next_out,
  output logic [7:0]       bit_mask_out,
  output logic [7:0]       write_data_out,
  output logic             carry_we_out,
  output logic             carry_out,
  output logic             illegal_out
);
  logic [15:0] ix1_a;
  logic [15:0] ix2_a;
  logic [15:0] rel_t;
  logic [15:0] btb_t;
  logic        tbit;
  logic [7:0]  mask;

  // geometry this datapath serves
  if (ADDR_W != IRB_AW || DATA_W != IRB_DW) begin : g_bad_geometry
    $error("irb_addr_gen: only 16-bit address and 8-bit data are supported");
  end

  // zero-page address from one operand byte
  function automatic logic [15:0] zero_page(input logic [7:0] low);
    return {8'h00, low};
  endfunction

  // mode codes this block knows
  function automatic logic mode_known(input irb_op_e m);
    case (m)
      IRB_OP_IX1, IRB_OP_IX2, IRB_OP_REL, IRB_OP_BSC, IRB_OP_BTB: mode_known = 1'b1;
      default: mode_known = 1'b0;
    endcase
  endfunction

  irb_alu u_alu (
    .index_in     (index_in),
    .byte1_in     (byte1_in),
    .byte2_in     (byte2_in),
    .pc_in        (pc_in),
    .ix1_addr_out (ix1_a),
    .ix2_addr_out (ix2_a),
    .rel_next_out (rel_t),
    .btb_next_out (btb_t)
  );

  for (genvar i = 0; i < 8; i++) begin : g_mask
    assign mask[i] = (bit_sel_in == 3'(i));
  end
  assign tbit = mem_data_in[bit_sel_in];

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      done_out <= 1'b0;
    end else begin
      done_out <= start_in;
    end
  end

  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      operand_address_out       <= IRB_ADDR_RESET;
      test_byte_address_out     <= IRB_ADDR_RESET;
      branch_target_address_out <= IRB_ADDR_RESET;
      pc_next_out               <= IRB_PC_RESET;
      bit_mask_out              <= IRB_BYTE_RESET;
      write_data_out            <= IRB_BYTE_RESET;
    end else begin
      if (start_in) begin
        case (mode_in)
          IRB_OP_IX1: begin
            operand_address_out <= ix1_a;                     // RULE1
            pc_next_out         <= pc_in + IRB_STEP_TWO;      // RULE1
          end
          IRB_OP_IX2: begin
            operand_address_out <= ix2_a;                     // RULE3
            pc_next_out         <= pc_in + IRB_STEP_THREE;    // RULE3
          end
          IRB_OP_REL: begin
            branch_target_address_out <= rel_t;               // RULE4
            pc_next_out <= cond_in ? rel_t : pc_in + IRB_STEP_TWO; // RULE5
          end
          IRB_OP_BSC: begin
            operand_address_out <= zero_page(byte1_in);       // RULE6
            bit_mask_out        <= mask;
            write_data_out      <= bit_pol_in ? (mem_data_in | mask)
                                              : (mem_data_in & ~mask); // RULE6
            pc_next_out         <= pc_in + IRB_STEP_TWO;      // RULE6
          end
          IRB_OP_BTB: begin
            test_byte_address_out     <= zero_page(byte1_in); // RULE7
            branch_target_address_out <= btb_t;
            bit_mask_out              <= mask;
            pc_next_out <= (tbit == bit_pol_in) ? btb_t : pc_in + IRB_STEP_THREE; // RULE7
          end
          default: begin
            pc_next_out <= pc_next_out;
          end
        endcase
      end
    end
  end

  // carry copy for bit test and branch
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      carry_we_out <= 1'b0;
      carry_out    <= 1'b0;
    end else begin
      carry_we_out <= start_in && (mode_in == IRB_OP_BTB);  // RULE8
      if (start_in && (mode_in == IRB_OP_BTB)) begin
        carry_out <= tbit;                                 // RULE8
      end
    end
  end

  // unknown mode code flag
  always_ff @(posedge clk_in or negedge rstn_in) begin
    if (!rstn_in) begin
      illegal_out <= 1'b0;
    end else begin
      illegal_out <= start_in && !mode_known(mode_in);
    end
  end

  // datapath and handshake checks
  a_ix1_pc: assert property (@(posedge clk_in) disable iff (!rstn_in) // RULE1
    start_in && mode_in == IRB_OP_IX1 |=> pc_next_out == $past(pc_in) + 16'h0002)
    else $error("ix1 pc step wrong");
  a_ix1_high: assert property (@(posedge clk_in) disable iff (!rstn_in) // RULE2
    start_in && mode_in == IRB_OP_IX1 |=>
      operand_address_out == {8'h00, $past(index_in)} + {8'h00, $past(byte1_in)})
    else $error("ix1 high byte wrong");
  a_ix2_pc: assert property (@(posedge clk_in) disable iff (!rstn_in) // RULE3
    start_in && mode_in == IRB_OP_IX2 |=> pc_next_out == $past(pc_in) + 16'h0003)
    else $error("ix2 pc step wrong");
  a_rel_fall: assert property (@(posedge clk_in) disable iff (!rstn_in) // RULE5
    start_in && mode_in == IRB_OP_REL && !cond_in |=> pc_next_out == $past(pc_in) + 16'h0002)
    else $error("untaken branch wrong");
  a_rel_take: assert property (@(posedge clk_in) disable iff (!rstn_in) // RULE5
    start_in && mode_in == IRB_OP_REL && cond_in |=>
      pc_next_out == $past(pc_in) + 16'h0002 + {{8{$past(byte1_in[7])}}, $past(byte1_in)})
    else $error("taken branch wrong");
  a_bsc_page: assert property (@(posedge clk_in) disable iff (!rstn_in) // RULE6
    start_in && mode_in == IRB_OP_BSC |=> operand_address_out == {8'h00, $past(byte1_in)})
    else $error("bit op not zero page");
  a_btb_page: assert property (@(posedge clk_in) disable iff (!rstn_in) // RULE7
    start_in && mode_in == IRB_OP_BTB |=> test_byte_address_out == {8'h00, $past(byte1_in)})
    else $error("bit test not zero page");
  a_btb_carry: assert property (@(posedge clk_in) disable iff (!rstn_in) // RULE8
    start_in && mode_in == IRB_OP_BTB |=> carry_we_out && carry_out == $past(tbit))
    else $error("carry not copied");
  a_ix2_addr: assert property (@(posedge clk_in) disable iff (!rstn_in) // RULE3
    start_in && mode_in == IRB_OP_IX2 |=>
      operand_address_out == {$past(byte1_in), $past(byte2_in)} + {8'h00, $past(index_in)})
    else $error("ix2 address wrong");
  a_rel_only: assert property (@(posedge clk_in) disable iff (!rstn_in) // RULE4
    !(start_in && (mode_in == IRB_OP_REL || mode_in == IRB_OP_BTB)) |=>
      $stable(branch_target_address_out))
    else $error("branch target moved outside a branch");
  a_bsc_keep: assert property (@(posedge clk_in) disable iff (!rstn_in) // RULE6
    start_in && mode_in == IRB_OP_BSC |=>
      ((write_data_out ^ $past(mem_data_in)) & ~bit_mask_out) == 8'h00)
    else $error("bit op touched other bits");
  a_bsc_bit: assert property (@(posedge clk_in) disable iff (!rstn_in) // RULE6
    start_in && mode_in == IRB_OP_BSC |=>
      (write_data_out & bit_mask_out) == ($past(bit_pol_in) ? bit_mask_out : 8'h00))
    else $error("bit op wrong value");
  a_mask_sel: assert property (@(posedge clk_in) disable iff (!rstn_in) // RULE6
    start_in && (mode_in == IRB_OP_BSC || mode_in == IRB_OP_BTB) |=>
      bit_mask_out == 8'h01 << $past(bit_sel_in))
    else $error("bit mask wrong");
  a_bsc_pc: assert property (@(posedge clk_in) disable iff (!rstn_in) // RULE6
    start_in && mode_in == IRB_OP_BSC |=> pc_next_out == $past(pc_in) + 16'h0002)
    else $error("bit op pc step wrong");
  a_btb_take: assert property (@(posedge clk_in) disable iff (!rstn_in) // RULE7
    start_in && mode_in == IRB_OP_BTB && tbit == bit_pol_in |=>
      pc_next_out == $past(pc_in) + 16'h0003 + {{8{$past(byte2_in[7])}}, $past(byte2_in)})
    else $error("bit test taken pc wrong");
  a_btb_fall: assert property (@(posedge clk_in) disable iff (!rstn_in) // RULE7
    start_in && mode_in == IRB_OP_BTB && tbit != bit_pol_in |=>
      pc_next_out == $past(pc_in) + 16'h0003)
    else $error("bit test untaken pc wrong");
  a_btb_target: assert property (@(posedge clk_in) disable iff (!rstn_in) // RULE7
    start_in && mode_in == IRB_OP_BTB |=> branch_target_address_out ==
      $past(pc_in) + 16'h0003 + {{8{$past(byte2_in[7])}}, $past(byte2_in)})
    else $error("bit test target wrong");
  a_done_pulse: assert property (@(posedge clk_in) disable iff (!rstn_in)
    done_out == $past(start_in))
    else $error("done not one cycle after start");
  a_carry_only: assert property (@(posedge clk_in) disable iff (!rstn_in) // RULE8
    !(start_in && mode_in == IRB_OP_BTB) |=> !carry_we_out)
    else $error("carry written outside bit test");
  a_illegal_flag: assert property (@(posedge clk_in) disable iff (!rstn_in)
    start_in && !mode_known(mode_in) |=> illegal_out && $stable(pc_next_out))
    else $error("unknown mode not flagged");

  // main scenarios
  c_ix2: cover property (@(posedge clk_in) start_in && mode_in == IRB_OP_IX2);
  c_rel: cover property (@(posedge clk_in) start_in && mode_in == IRB_OP_REL && cond_in);
  c_btb: cover property (@(posedge clk_in) start_in && mode_in == IRB_OP_BTB);
  c_ix1_carry: cover property (@(posedge clk_in)
    start_in && mode_in == IRB_OP_IX1 && index_in > ~byte1_in);
  c_btb_taken: cover property (@(posedge clk_in)
    start_in && mode_in == IRB_OP_BTB && tbit == bit_pol_in);
endmodule // irb_addr_gen

// [rtl/irb_alu.sv]
// Purpose: address arithmetic for the generator
// Assumes: combinational, same clock as caller
// Notes: outputs registered by the caller
`timescale 1ns/10ps
module irb_alu
  import irb_pkg::*;
(
  // operands
  input  wire logic [7:0]  index_in,
  input  wire logic [7:0]  byte1_in,
  input  wire logic [7:0]  byte2_in,
  input  wire logic [15:0] pc_in,
  // results
  output logic      [15:0] ix1_addr_out,
  output logic      [15:0] ix2_addr_out,
  output logic      [15:0] rel_next_out,
  output logic      [15:0] btb_next_out
);
  logic [8:0] sum1;
  logic [8:0] sum2;
  assign sum1 = {1'b0, index_in} + {1'b0, byte1_in};
  assign sum2 = {1'b0, index_in} + {1'b0, byte2_in};
  assign ix1_addr_out = {7'h00, sum1};                               // RULE2
  assign ix2_addr_out = {byte1_in + {7'h00, sum2[8]}, sum2[7:0]};    // RULE3
  // relative branch target from opcode address: pc+2+disp
  assign rel_next_out = pc_in + IRB_STEP_TWO + {{8{byte1_in[7]}}, byte1_in}; // RULE5
  assign btb_next_out = pc_in + IRB_STEP_THREE + {{8{byte2_in[7]}}, byte2_in}; // RULE7
endmodule // irb_alu

// [rtl/irb_pkg.sv]
// Purpose: constants and types for the indexed/relative/bit address generator
// Assumes: 16-bit address, 8-bit data, 50 MHz core clock
// Notes: tags below mark where each rule is carried out
// Function
// (RULE1) short-offset indexed: address = index + offset byte, pc advances two
// (RULE2) short-offset indexed: high byte is the carry, low byte the 8-bit sum
// (RULE3) long-offset indexed: low = index + byte two, high = byte one + carry, pc+3
// (RULE4) relative addressing serves only branch instructions
// (RULE5) branch adds signed displacement only when condition holds; else next instruction
// (RULE6) bit set/clear: bit from opcode, zero-page address, modify one bit, pc+2
// (RULE7) bit test branch: test selected bit/polarity; taken pc+3+disp else pc+3
// (RULE8) bit test branch copies tested bit into carry, taken or not
package irb_pkg;
  localparam int unsigned IRB_AW = 16;
  localparam int unsigned IRB_DW = 8;
  localparam logic [15:0] IRB_PC_RESET = 16'h0000;
  localparam logic [15:0] IRB_ADDR_RESET = 16'h0000;
  localparam logic [7:0]  IRB_BYTE_RESET = 8'h00;
  localparam logic [15:0] IRB_STEP_TWO = 16'h0002;
  localparam logic [15:0] IRB_STEP_THREE = 16'h0003;
  typedef enum logic [2:0] {
    IRB_OP_IX1,
    IRB_OP_IX2,
    IRB_OP_REL,
    IRB_OP_BSC,
    IRB_OP_BTB
  } irb_op_e;
endpackage : irb_pkg

// [tb/test_indexed_relative_bit_addr_gen.sv]
// Purpose: self-checking bench for the address generator
// Assumes: answer registered one cycle after start_in
// Notes: lfsr operands plus corner cases
`timescale 1ns/10ps
module test_indexed_relative_bit_addr_gen;
  import irb_pkg::*;
  logic        clk_in, rstn_in, start_in, cond_in, bit_pol_in;
  irb_op_e     mode_in;
  logic [15:0] pc_in, opa, tba, bta, pcn, lfsr_r;
  logic [7:0]  index_in, byte1_in, byte2_in, mem_data_in, msk, wd;
  logic [2:0]  bit_sel_in;
  logic        done, cwe, cy, ill;
  logic [63:0] rnd;
  int          failures, n_compared;
  irb_addr_gen irb_addr_gen_inst (.clk_in(clk_in), .rstn_in(rstn_in), .start_in(start_in),
    .mode_in(mode_in), .pc_in(pc_in), .index_in(index_in), .byte1_in(byte1_in),
    .byte2_in(byte2_in), .cond_in(cond_in), .bit_sel_in(bit_sel_in), .bit_pol_in(bit_pol_in),
    .mem_data_in(mem_data_in), .done_out(done), .operand_address_out(opa),
    .test_byte_address_out(tba), .branch_target_address_out(bta), .pc_next_out(pcn),
    .bit_mask_out(msk), .write_data_out(wd), .carry_we_out(cwe), .carry_out(cy),
    .illegal_out(ill));
  function automatic logic [15:0] lfsr(input logic [15:0] v);
    return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
  endfunction
  function automatic logic [15:0] sx(input logic [7:0] b);
    return {{8{b[7]}}, b};
  endfunction
  task automatic check(input string what, input logic [15:0] seen, exp);
    n_compared++;
    if (seen !== exp) begin
      failures++;
      $display("unexpected %s: expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic conclude();
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task automatic op(input irb_op_e m, input logic [15:0] pc, input logic [7:0] x, b1, b2, md,
                    input logic c, pol, input logic [2:0] sel);
    logic hit;
    logic [15:0] prev;
    hit = (md[sel] == pol);
    prev = pcn;
    @(posedge clk_in);
    mode_in <= m;
    {pc_in, index_in, byte1_in, byte2_in, mem_data_in} <= {pc, x, b1, b2, md};
    {cond_in, bit_pol_in, bit_sel_in, start_in} <= {c, pol, sel, 1'b1};
    @(posedge clk_in);
    start_in <= 1'b0;
    #1;
    check("done", done, 1'b1);
    check("carry we", cwe, m == IRB_OP_BTB);
    check("illegal flag", ill, m > IRB_OP_BTB);
    case (m)
      IRB_OP_IX1: begin
        check("ix1 addr", opa, {7'h00, {1'b0, x} + {1'b0, b1}});
        check("ix1 pc", pcn, pc + 16'h0002);
      end
      IRB_OP_IX2: begin
        check("ix2 addr", opa, {b1, b2} + {8'h00, x});
        check("ix2 pc", pcn, pc + 16'h0003);
      end
      IRB_OP_REL: begin
        check("rel target", bta, pc + 16'h0002 + sx(b1));
        check("rel pc", pcn, pc + 16'h0002 + (c ? sx(b1) : 16'h0000));
      end
      IRB_OP_BSC: begin
        check("bsc addr", opa, {8'h00, b1});
        check("bsc mask", msk, 8'h01 << sel);
        check("bsc data", wd, pol ? md | (8'h01 << sel) : md & ~(8'h01 << sel));
        check("bsc pc", pcn, pc + 16'h0002);
      end
      IRB_OP_BTB: begin
        check("btb addr", tba, {8'h00, b1});
        check("btb pc", pcn, pc + 16'h0003 + (hit ? sx(b2) : 16'h0000));
        check("btb carry", cy, md[sel]);
        check("btb target", bta, pc + 16'h0003 + sx(b2));
        check("btb mask", msk, 8'h01 << sel);
      end
      default: begin
        check("illegal", ill, 1'b1);
        check("illegal hold", pcn, prev);
      end
    endcase
  endtask
  initial begin
    clk_in = 1'b0;
    forever #10 clk_in = ~clk_in;
  end
  initial begin
    repeat (3000) @(posedge clk_in);
    failures++;
    conclude();
  end
  initial begin
    failures = 0;
    n_compared = 0;
    lfsr_r = 16'hEA02;
    rstn_in = 1'b0;
    mode_in = IRB_OP_IX1;
    {start_in, cond_in, bit_pol_in, pc_in, index_in, byte1_in, byte2_in} = '0;
    {mem_data_in, bit_sel_in} = '0;
    repeat (8) @(posedge clk_in);
    check("reset pc", pcn, IRB_PC_RESET);
    rstn_in <= 1'b1;
    op(IRB_OP_IX1, 16'h0100, 8'hF0, 8'h20, 8'h00, 8'h00, 1'b0, 1'b0, 3'h0);
    op(IRB_OP_IX1, 16'hFFFF, 8'hFF, 8'hFF, 8'h00, 8'h00, 1'b0, 1'b0, 3'h0);
    op(IRB_OP_IX2, 16'h0200, 8'hFF, 8'h12, 8'h01, 8'h00, 1'b0, 1'b0, 3'h0);
    op(IRB_OP_REL, 16'h0400, 8'h00, 8'h80, 8'h00, 8'h00, 1'b1, 1'b0, 3'h0);
    op(IRB_OP_REL, 16'h0400, 8'h00, 8'h7F, 8'h00, 8'h00, 1'b1, 1'b0, 3'h0);
    op(IRB_OP_REL, 16'h0400, 8'h00, 8'h7F, 8'h00, 8'h00, 1'b0, 1'b0, 3'h0);
    op(IRB_OP_BSC, 16'h0500, 8'h00, 8'h33, 8'h00, 8'h00, 1'b0, 1'b1, 3'h7);
    op(IRB_OP_BSC, 16'h0500, 8'h00, 8'h33, 8'h00, 8'hFF, 1'b0, 1'b0, 3'h0);
    op(IRB_OP_BTB, 16'h0600, 8'h00, 8'h44, 8'h80, 8'h08, 1'b0, 1'b1, 3'h3);
    op(IRB_OP_BTB, 16'h0600, 8'h00, 8'h44, 8'h7F, 8'h08, 1'b0, 1'b0, 3'h3);
    op(irb_op_e'(3'h7), 16'h0700, 8'h00, 8'h00, 8'h00, 8'h00, 1'b0, 1'b0, 3'h0);
    @(posedge clk_in);
    rstn_in <= 1'b0;
    repeat (2) @(posedge clk_in);
    check("reset pc again", pcn, IRB_PC_RESET);
    check("reset addr", opa, IRB_ADDR_RESET);
    rstn_in <= 1'b1;
    $display("corner tests done");
    repeat (400) begin
      for (int k = 0; k < 4; k++) begin
        lfsr_r = lfsr(lfsr_r);
        rnd[k*16 +: 16] = lfsr_r;
      end
      op(irb_op_e'(rnd[2:0] % 3'd5), rnd[18:3], rnd[26:19], rnd[34:27], rnd[42:35],
         rnd[50:43], rnd[51], rnd[52], rnd[55:53]);
    end
    $display("random tests done");
    conclude();
  end
endmodule // test_indexed_relative_bit_addr_gen
